// ==== rtl/mrw_pkg.sv ====
package mrw_pkg;

  localparam logic [7:0] CMD_DUAL_IO    = 8'hbb;
  localparam logic [7:0] CMD_QUAD_IO    = 8'heb;
  localparam logic [7:0] CMD_QUAD_WORD  = 8'he7;
  localparam logic [7:0] CMD_SET_WRAP   = 8'h77;
  localparam logic [7:0] CMD_ID_READ    = 8'h90;
  localparam logic [7:0] CMD_CONT_RESET = 8'hff;

  localparam logic [4:0] INSTR_CLKS        = 5'h08;
  localparam logic [4:0] WRAP_CLKS         = 5'h08;
  localparam logic [4:0] WRAP_CAPTURE_CLK  = 5'h07;
  localparam logic [4:0] QUAD_DUMMY_CLKS   = 5'h04;
  localparam logic [4:0] WORD_DUMMY_CLKS   = 5'h02;
  localparam logic [4:0] CONT_RESET_CLKS   = 5'h10;
  localparam logic [4:0] ADDR_BITS         = 5'h18;
  localparam logic [4:0] BYTE_BITS         = 5'h08;
  localparam logic [4:0] CS_HIGH_HALVES    = 5'h04;

  localparam logic [1:0] MODE_CONT_SEL     = 2'b10;
  localparam int         MODE_SEL_POS      = 4;
  localparam int         WRAP_DIS_POS      = 0;
  localparam int         WRAP_LEN_POS      = 1;
  localparam logic       WRAP_DIS_RESET    = 1'b1;
  localparam logic [1:0] WRAP_LEN_RESET    = 2'b00;
  localparam logic [7:0] WRAP_MIN_BYTES    = 8'h08;

  typedef enum logic [2:0] {
    PH_START, PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA, PH_WRAP, PH_SKIP
  } mrw_phase_t;

  typedef enum logic [1:0] {CM_NONE, CM_DUAL, CM_QUAD, CM_WORD} mrw_cont_t;

  // Bits carried per serial clock
  function automatic logic [2:0] lane_width(input mrw_phase_t ph, input logic [7:0] cmd);
    if (ph == PH_CMD) begin
      return 3'd1;
    end
    if (ph == PH_WRAP || ph == PH_SKIP) begin
      return 3'd4;
    end
    case (cmd)
      CMD_DUAL_IO:                 return 3'd2;
      CMD_QUAD_IO, CMD_QUAD_WORD:  return 3'd4;
      default:                     return 3'd1;
    endcase
  endfunction

  // Serial clocks spent in a phase
  function automatic logic [4:0] phase_clks(input mrw_phase_t ph, input logic [7:0] cmd);
    logic [4:0] w;
    w = {2'b00, lane_width(ph, cmd)};
    case (ph)
      PH_CMD:   return INSTR_CLKS;
      PH_ADDR:  return ADDR_BITS / w;
      PH_MODE:  return BYTE_BITS / w;
      PH_DUMMY: return (cmd == CMD_QUAD_WORD) ? WORD_DUMMY_CLKS : QUAD_DUMMY_CLKS;
      PH_DATA:  return BYTE_BITS / w;
      PH_WRAP:  return WRAP_CLKS;
      default:  return CONT_RESET_CLKS;
    endcase
  endfunction

  function automatic mrw_phase_t next_phase(input mrw_phase_t ph, input logic [7:0] cmd);
    case (ph)
      PH_CMD: begin
        case (cmd)
          CMD_DUAL_IO, CMD_QUAD_IO, CMD_QUAD_WORD, CMD_ID_READ: return PH_ADDR;
          CMD_SET_WRAP: return PH_WRAP;
          default:      return PH_SKIP;
        endcase
      end
      PH_ADDR:  return (cmd == CMD_ID_READ) ? PH_DATA : PH_MODE;
      PH_MODE:  return (cmd == CMD_DUAL_IO) ? PH_DATA : PH_DUMMY;
      PH_DUMMY: return PH_DATA;
      PH_WRAP:  return PH_SKIP;
      default:  return ph;
    endcase
  endfunction

  function automatic mrw_cont_t cont_of(input logic [7:0] cmd);
    case (cmd)
      CMD_DUAL_IO:   return CM_DUAL;
      CMD_QUAD_IO:   return CM_QUAD;
      CMD_QUAD_WORD: return CM_WORD;
      default:       return CM_NONE;
    endcase
  endfunction

endpackage

// ==== rtl/mrw_link_if.sv ====
`timescale 1ns/1ps
interface mrw_link_if;
  logic       sclk;
  logic       cs_n;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // Wire level with pull-up when nobody drives
  assign io = (host_io_oe & host_io_o) | (dev_io_oe & dev_io_o) | ~(host_io_oe | dev_io_oe);

  modport host (output sclk, output cs_n, output host_io_o, output host_io_oe, input io);
  modport dev  (input sclk, input cs_n, input io, output dev_io_o, output dev_io_oe);
endinterface

// ==== rtl/mrw_flash_dev.sv ====
// Behaviour
// - Dual read: address, mode two bits per clock
// - Address advances by one after each byte
// - Mode bits 10 keep instruction-less continuous reads
// - Other mode bits leave continuous read mode
// - Continuous mode reset clears retained mode bits
// - Quad read: address, mode, four dummies, quad data
// - Quad reads need quad enable bit set
// - Word quad read: even address, two dummies
// - Wrap instruction: 24 dummy then wrap bits
// - Stored wrap setting applies to later quad reads
// - Wrapped output returns to aligned section start
// - Wrap disable bit powers up set
// - Wrap length selects 8/16/32/64 byte section
// - ID read alternates manufacturer and device codes
// - Quad nibbles MSB first, line 3 highest
// - Wrap bits on lines 0..2, seventh clock
// - Sample on rising edge, drive on falling
`timescale 1ns/1ps
module mrw_flash_dev #(
  parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'ha5  // Arbitrary value
) (
  input  wire logic        i_reset,
  input  wire logic        i_quad_lines_enable_bit,
  input  wire logic [7:0]  i_mem_data,
  output      logic [23:0] o_mem_addr,
  mrw_link_if.dev          link
);

  logic                  frame_rst;
  logic                  qe_s1_q;
  logic                  qe_s2_q;
  mrw_pkg::mrw_cont_t    cont_q;
  mrw_pkg::mrw_cont_t    cont_d;
  logic                  wrap_dis_q;
  logic                  wrap_dis_d;
  logic [1:0]            wrap_len_q;
  logic [1:0]            wrap_len_d;
  mrw_pkg::mrw_phase_t   phase_q;
  mrw_pkg::mrw_phase_t   phase_d;
  mrw_pkg::mrw_phase_t   ph;
  logic [4:0]            cnt_q;
  logic [4:0]            cnt_d;
  logic [7:0]            cmd_q;
  logic [7:0]            cmd_d;
  logic [7:0]            cmd;
  logic [7:0]            mode_q;
  logic [7:0]            mode_d;
  logic [7:0]            sh_q;
  logic [7:0]            sh_d;
  logic [23:0]           addr_q;
  logic [23:0]           addr_d;
  logic [2:0]            w;
  logic [3:0]            chunk;
  logic                  last;
  logic                  wrap_on;
  logic [3:0]            dio_q;
  logic [3:0]            dio_d;
  logic [3:0]            doe_q;
  logic [3:0]            doe_d;

  // Next byte address, wrapping inside an aligned section when enabled
  function automatic logic [23:0] advance(input logic [23:0] a, input logic wrap,
                                          input logic [1:0] len);
    logic [7:0] m;
    logic [7:0] inc;
    m   = (mrw_pkg::WRAP_MIN_BYTES << len) - 8'h01;
    inc = a[7:0] + 8'h01;
    if (wrap) begin
      return {a[23:8], (inc & m) | (a[7:0] & ~m)};
    end
    return a + 24'h00_0001;
  endfunction

  // Frame state dies with chip select
  assign frame_rst = link.cs_n | i_reset;

  always_comb begin
    ph  = phase_q;
    cmd = cmd_q;
    if (phase_q == mrw_pkg::PH_START) begin
      ph = (cont_q != mrw_pkg::CM_NONE) ? mrw_pkg::PH_ADDR : mrw_pkg::PH_CMD;
      case (cont_q)
        mrw_pkg::CM_DUAL: cmd = mrw_pkg::CMD_DUAL_IO;
        mrw_pkg::CM_QUAD: cmd = mrw_pkg::CMD_QUAD_IO;
        mrw_pkg::CM_WORD: cmd = mrw_pkg::CMD_QUAD_WORD;
        default:          cmd = cmd_q;
      endcase
    end
    w = mrw_pkg::lane_width(ph, cmd);
    case (w)
      3'd4:    chunk = link.io;
      3'd2:    chunk = {2'b00, link.io[1:0]};
      default: chunk = {3'b000, link.io[0]};
    endcase
    last    = (cnt_q == mrw_pkg::phase_clks(ph, cmd) - 5'h01);
    wrap_on = !wrap_dis_q &&
              (cmd == mrw_pkg::CMD_QUAD_IO || cmd == mrw_pkg::CMD_QUAD_WORD);
    phase_d = ph;
    cnt_d   = cnt_q + 5'h01;
    cmd_d   = cmd;
    addr_d  = addr_q;
    mode_d  = mode_q;
    sh_d    = sh_q;
    case (ph)
      mrw_pkg::PH_CMD:  cmd_d  = {cmd_q[6:0], link.io[0]};
      mrw_pkg::PH_ADDR: addr_d = (addr_q << w) | {20'h0_0000, chunk};
      mrw_pkg::PH_MODE: mode_d = (mode_q << w) | {4'h0, chunk};
      mrw_pkg::PH_DATA: sh_d   = sh_q << w;
      default: ;
    endcase
    if (last) begin
      cnt_d   = 5'h00;
      phase_d = mrw_pkg::next_phase(ph, cmd_d);
      if (ph == mrw_pkg::PH_CMD && phase_d == mrw_pkg::PH_ADDR && !qe_s2_q &&
          (cmd_d == mrw_pkg::CMD_QUAD_IO || cmd_d == mrw_pkg::CMD_QUAD_WORD)) begin
        phase_d = mrw_pkg::PH_SKIP;
      end
      if (phase_d == mrw_pkg::PH_DATA) begin
        if (cmd_d == mrw_pkg::CMD_ID_READ) begin
          sh_d = addr_d[0] ? DEV_ID : MFR_ID;
        end else begin
          sh_d = i_mem_data;
        end
        addr_d = advance(addr_d, wrap_on, wrap_len_q);
      end
    end
  end

  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      phase_q <= mrw_pkg::PH_START;
      cnt_q   <= 5'h00;
      cmd_q   <= 8'h00;
      addr_q  <= 24'h00_0000;
      mode_q  <= 8'h00;
      sh_q    <= 8'h00;
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      cmd_q   <= cmd_d;
      addr_q  <= addr_d;
      mode_q  <= mode_d;
      sh_q    <= sh_d;
    end
  end

  // Retained mode and wrap settings
  always_comb begin
    cont_d     = cont_q;
    wrap_dis_d = wrap_dis_q;
    wrap_len_d = wrap_len_q;
    if (ph == mrw_pkg::PH_MODE && last) begin
      if (mode_d[mrw_pkg::MODE_SEL_POS +: 2] == mrw_pkg::MODE_CONT_SEL) begin
        cont_d = mrw_pkg::cont_of(cmd);
      end else begin
        cont_d = mrw_pkg::CM_NONE;
      end
    end
    if (ph == mrw_pkg::PH_WRAP && cnt_q == mrw_pkg::WRAP_CAPTURE_CLK - 5'h01) begin
      wrap_dis_d = link.io[mrw_pkg::WRAP_DIS_POS];
      wrap_len_d = link.io[mrw_pkg::WRAP_LEN_POS +: 2];
    end
  end

  always_ff @(posedge link.sclk or posedge i_reset) begin
    if (i_reset) begin
      qe_s1_q    <= 1'b0;
      qe_s2_q    <= 1'b0;
      cont_q     <= mrw_pkg::CM_NONE;
      wrap_dis_q <= mrw_pkg::WRAP_DIS_RESET;
      wrap_len_q <= mrw_pkg::WRAP_LEN_RESET;
    end else begin
      qe_s1_q    <= i_quad_lines_enable_bit;
      qe_s2_q    <= qe_s1_q;
      cont_q     <= cont_d;
      wrap_dis_q <= wrap_dis_d;
      wrap_len_q <= wrap_len_d;
    end
  end

  // Output lanes for the coming clock
  always_comb begin
    dio_d = 4'h0;
    doe_d = 4'h0;
    if (phase_q == mrw_pkg::PH_DATA) begin
      case (w)
        3'd4: begin
          dio_d = sh_q[7:4];
          doe_d = 4'hf;
        end
        3'd2: begin
          dio_d = {2'b00, sh_q[7:6]};
          doe_d = 4'h3;
        end
        default: begin
          dio_d = {2'b00, sh_q[7], 1'b0};
          doe_d = 4'h2;
        end
      endcase
    end
  end

  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      dio_q <= 4'h0;
      doe_q <= 4'h0;
    end else begin
      dio_q <= dio_d;
      doe_q <= doe_d;
    end
  end

  assign link.dev_io_o  = dio_q;
  assign link.dev_io_oe = doe_q;
  assign o_mem_addr     = addr_q;

endmodule // mrw_flash_dev

// ==== rtl/mrw_host_ctl.sv ====
`timescale 1ns/1ps
module mrw_host_ctl #(
  parameter int HALF_DIV = 4,
  parameter int DEPTH    = 2,
  parameter int WIDTH    = 8
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_req_valid,
  output      logic        o_req_ready,
  input  wire logic [7:0]  i_req_cmd,
  input  wire logic [23:0] i_req_addr,
  input  wire logic        i_req_stay_cont,
  input  wire logic        i_req_wrap_dis,
  input  wire logic [1:0]  i_req_wrap_len,
  input  wire logic [15:0] i_req_len,
  output      logic        o_rd_valid,
  input  wire logic        i_rd_ready,
  output      logic [7:0]  o_rd_data,
  output      logic        o_busy,
  output      logic        o_cont_active,
  output      logic        o_wrap_enabled,
  mrw_link_if.host         link
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  generate
    if (HALF_DIV < 2 || HALF_DIV > 255 || DEPTH != 2 || WIDTH != 8) begin : g_bad
      $error("mrw_host_ctl: unsupported parameter values");
    end
  endgenerate

  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_GAP} mrw_hstate_t;

  mrw_hstate_t           st_q;
  mrw_hstate_t           st_d;
  logic [7:0]            div_q;
  logic [7:0]            div_d;
  logic                  sclk_q;
  logic                  sclk_d;
  logic                  cs_n_q;
  logic                  cs_n_d;
  mrw_pkg::mrw_phase_t   ph_q;
  mrw_pkg::mrw_phase_t   ph_d;
  logic [4:0]            cnt_q;
  logic [4:0]            cnt_d;
  logic [7:0]            cmd_q;
  logic [7:0]            cmd_d;
  logic [39:0]           tx_q;
  logic [39:0]           tx_d;
  logic [15:0]           len_q;
  logic [15:0]           len_d;
  logic [7:0]            rx_q;
  logic [7:0]            rx_d;
  logic                  stay_q;
  logic                  stay_d;
  logic                  wdis_q;
  logic                  wdis_d;
  mrw_pkg::mrw_cont_t    cont_q;
  mrw_pkg::mrw_cont_t    cont_d;
  logic                  wrap_en_q;
  logic                  wrap_en_d;
  logic [3:0]            io_o_q;
  logic [3:0]            io_o_d;
  logic [3:0]            io_oe_q;
  logic [3:0]            io_oe_d;
  logic [3:0]            io_s1_q;
  logic [3:0]            io_s2_q;
  logic [WIDTH-1:0]      fifo_q [DEPTH];
  logic [PW-1:0]         wp_q;
  logic [PW-1:0]         rp_q;
  logic [CW-1:0]         fcnt_q;
  logic                  push;
  logic                  pop;
  logic                  tick;
  logic                  last;
  logic                  done;
  logic                  mismatch;
  logic [2:0]            w;
  logic [2:0]            wn;
  logic [3:0]            chunk;
  logic [7:0]            mode_byte;
  logic [4:0]            rst_drive;

  // Reset frame lets go of the lanes before a quad device may drive data
  assign rst_drive = mrw_pkg::phase_clks(mrw_pkg::PH_ADDR, mrw_pkg::CMD_QUAD_IO) +
                     mrw_pkg::phase_clks(mrw_pkg::PH_MODE, mrw_pkg::CMD_QUAD_IO);
  assign tick     = (div_q == 8'(HALF_DIV - 1));
  assign mismatch = (cont_q != mrw_pkg::CM_NONE) &&
                    (mrw_pkg::cont_of(i_req_cmd) != cont_q);
  assign o_req_ready = (st_q == HS_IDLE) && (!mismatch || i_req_cmd == mrw_pkg::CMD_CONT_RESET);

  always_comb begin
    st_d      = st_q;
    div_d     = tick ? 8'h00 : div_q + 8'h01;
    sclk_d    = sclk_q;
    cs_n_d    = cs_n_q;
    ph_d      = ph_q;
    cnt_d     = cnt_q;
    cmd_d     = cmd_q;
    tx_d      = tx_q;
    len_d     = len_q;
    rx_d      = rx_q;
    stay_d    = stay_q;
    wdis_d    = wdis_q;
    cont_d    = cont_q;
    wrap_en_d = wrap_en_q;
    push      = 1'b0;
    done      = 1'b0;
    w         = mrw_pkg::lane_width(ph_q, cmd_q);
    last      = (cnt_q == mrw_pkg::phase_clks(ph_q, cmd_q) - 5'h01);
    mode_byte = i_req_stay_cont ? {2'b00, mrw_pkg::MODE_CONT_SEL, 4'h0} : 8'h00;
    case (w)
      3'd4:    chunk = io_s2_q;
      3'd2:    chunk = {2'b00, io_s2_q[1:0]};
      default: chunk = {3'b000, io_s2_q[1]};
    endcase
    case (st_q)
      HS_IDLE: begin
        if (i_req_valid && (mismatch || i_req_cmd == mrw_pkg::CMD_CONT_RESET)) begin
          ph_d  = mrw_pkg::PH_SKIP;
          cmd_d = mrw_pkg::CMD_CONT_RESET;
          tx_d  = '1;
        end else if (i_req_valid) begin
          cmd_d  = i_req_cmd;
          len_d  = i_req_len;
          stay_d = i_req_stay_cont;
          wdis_d = i_req_wrap_dis;
          ph_d   = mrw_pkg::PH_CMD;
          tx_d   = {i_req_cmd, i_req_addr, mode_byte};
          if (i_req_cmd == mrw_pkg::CMD_SET_WRAP) begin
            tx_d = {i_req_cmd, 24'h00_0000, 1'b0, i_req_wrap_len, i_req_wrap_dis,
                    4'h0};
          end else if (i_req_cmd == mrw_pkg::CMD_QUAD_WORD) begin
            tx_d = {i_req_cmd, i_req_addr[23:1], 1'b0, mode_byte};
          end
          if (cont_q != mrw_pkg::CM_NONE) begin
            ph_d = mrw_pkg::PH_ADDR;
            tx_d = {tx_d[31:0], 8'h00};
          end
        end
        if (i_req_valid) begin
          st_d   = HS_RUN;
          cs_n_d = 1'b0;
          sclk_d = 1'b0;
          cnt_d  = 5'h00;
          div_d  = 8'h00;
        end
      end
      HS_RUN: begin
        if (tick && !sclk_q) begin
          if (!(ph_q == mrw_pkg::PH_DATA && fcnt_q == CW'(DEPTH))) begin
            sclk_d = 1'b1;
          end
        end else if (tick) begin
          sclk_d = 1'b0;
          cnt_d  = cnt_q + 5'h01;
          tx_d   = tx_q << w;
          if (ph_q == mrw_pkg::PH_DATA) begin
            rx_d = (rx_q << w) | {4'h0, chunk};
          end
          if (last) begin
            cnt_d = 5'h00;
            ph_d  = mrw_pkg::next_phase(ph_q, cmd_q);
            case (ph_q)
              mrw_pkg::PH_DATA: begin
                push  = 1'b1;
                len_d = len_q - 16'h0001;
                done  = (len_q == 16'h0001);
              end
              mrw_pkg::PH_MODE: begin
                cont_d = stay_q ? mrw_pkg::cont_of(cmd_q) : mrw_pkg::CM_NONE;
              end
              mrw_pkg::PH_WRAP: begin
                wrap_en_d = !wdis_q;
                done      = 1'b1;
              end
              mrw_pkg::PH_SKIP: begin
                cont_d = mrw_pkg::CM_NONE;
                done   = 1'b1;
              end
              default: ;
            endcase
          end
          if (done) begin
            st_d   = HS_GAP;
            cs_n_d = 1'b1;
            ph_d   = mrw_pkg::PH_START;
          end
        end
      end
      HS_GAP: begin
        if (tick) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == mrw_pkg::CS_HIGH_HALVES - 5'h01) begin
            st_d  = HS_IDLE;
            cnt_d = 5'h00;
          end
        end
      end
      default: st_d = HS_IDLE;
    endcase
    wn      = mrw_pkg::lane_width(ph_d, cmd_d);
    io_o_d  = 4'h0;
    io_oe_d = 4'h0;
    if (cs_n_d == 1'b0 && (ph_d == mrw_pkg::PH_CMD || ph_d == mrw_pkg::PH_ADDR ||
        ph_d == mrw_pkg::PH_MODE || ph_d == mrw_pkg::PH_WRAP ||
        (ph_d == mrw_pkg::PH_SKIP && cnt_d < rst_drive))) begin
      case (wn)
        3'd4: begin
          io_o_d  = tx_d[39:36];
          io_oe_d = 4'hf;
        end
        3'd2: begin
          io_o_d  = {2'b00, tx_d[39:38]};
          io_oe_d = 4'h3;
        end
        default: begin
          io_o_d  = {3'b000, tx_d[39]};
          io_oe_d = 4'h1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_q      <= HS_IDLE;
      div_q     <= 8'h00;
      sclk_q    <= 1'b0;
      cs_n_q    <= 1'b1;
      ph_q      <= mrw_pkg::PH_START;
      cnt_q     <= 5'h00;
      cmd_q     <= 8'h00;
      tx_q      <= 40'h00_0000_0000;
      len_q     <= 16'h0000;
      rx_q      <= 8'h00;
      stay_q    <= 1'b0;
      wdis_q    <= mrw_pkg::WRAP_DIS_RESET;
      cont_q    <= mrw_pkg::CM_NONE;
      wrap_en_q <= !mrw_pkg::WRAP_DIS_RESET;
      io_o_q    <= 4'h0;
      io_oe_q   <= 4'h0;
      io_s1_q   <= 4'h0;
      io_s2_q   <= 4'h0;
    end else begin
      st_q      <= st_d;
      div_q     <= div_d;
      sclk_q    <= sclk_d;
      cs_n_q    <= cs_n_d;
      ph_q      <= ph_d;
      cnt_q     <= cnt_d;
      cmd_q     <= cmd_d;
      tx_q      <= tx_d;
      len_q     <= len_d;
      rx_q      <= rx_d;
      stay_q    <= stay_d;
      wdis_q    <= wdis_d;
      cont_q    <= cont_d;
      wrap_en_q <= wrap_en_d;
      io_o_q    <= io_o_d;
      io_oe_q   <= io_oe_d;
      io_s1_q   <= link.io;
      io_s2_q   <= io_s1_q;
    end
  end

  // Two-entry read buffer
  assign pop = o_rd_valid && i_rd_ready;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wp_q   <= '0;
      rp_q   <= '0;
      fcnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        fifo_q[i] <= '0;
      end
    end else begin
      if (push) begin
        fifo_q[wp_q] <= rx_d;
        wp_q         <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      fcnt_q <= fcnt_q + CW'(push) - CW'(pop);
    end
  end

  assign o_rd_valid      = (fcnt_q != '0);
  assign o_rd_data       = fifo_q[rp_q];
  assign o_busy          = (st_q != HS_IDLE);
  assign o_cont_active   = (cont_q != mrw_pkg::CM_NONE);
  assign o_wrap_enabled  = wrap_en_q;
  assign link.sclk       = sclk_q;
  assign link.cs_n       = cs_n_q;
  assign link.host_io_o  = io_o_q;
  assign link.host_io_oe = io_oe_q;

endmodule // mrw_host_ctl

// ==== verification/mrw_link_sva.sv ====
`timescale 1ns/1ps
module mrw_link_sva #(
  parameter int HALF_DIV = 4
) (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe
);
  logic [7:0] gap_q;
  logic [7:0] gap_d;

  // Cycles spent deselected
  always_comb begin
    gap_d = cs_n ? gap_q + {7'h00, gap_q != 8'hff} : 8'h00;
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      gap_q <= 8'hff;
    end else begin
      gap_q <= gap_d;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence lead_s;
    !sclk ##1 !sclk;
  endsequence

  idle_low_a:
    assert property (cs_n |-> !sclk) else $error("clock not idle");
  no_contend_a:
    assert property ((host_io_oe & dev_io_oe) == 4'h0) else $error("lane contention");
  dev_quiet_a:
    assert property (cs_n && $past(cs_n) |-> dev_io_oe == 4'h0) else $error("device drives");
  cs_gap_a:
    assert property ($fell(cs_n) |-> gap_q >= 8'(4 * HALF_DIV)) else $error("short gap");
  host_hold_a:
    assert property (!cs_n && sclk && $past(sclk) |-> $stable(host_io_o))
      else $error("host lanes moved");
  dev_hold_a:
    assert property (!cs_n && sclk && $past(sclk) |-> $stable(dev_io_o))
      else $error("device lanes moved");
  start_low_a:
    assert property ($fell(cs_n) |-> lead_s) else $error("clock not low at select");
  first_lane_a:
    assert property ($fell(cs_n) |-> host_io_oe[0]) else $error("lane 0 not driven");
endmodule // mrw_link_sva

// ==== verification/tb_multi_io_read_wrap_id_frontend.sv ====
`timescale 1ns/1ps
module tb_multi_io_read_wrap_id_frontend;
  localparam logic [7:0] MFR = 8'h5a; // Arbitrary value
  localparam logic [7:0] DEV = 8'ha5; // Arbitrary value
  logic        clk = 1'b0;
  logic        rst = 1'b0;
  logic        qe = 1'b1;
  logic        vld = 1'b0;
  logic        rdy = 1'b1;
  logic        stay = 1'b0;
  logic        wdis = 1'b1;
  logic [1:0]  wlen = 2'b00;
  logic [7:0]  cmd = 8'h00;
  logic [23:0] adr = 24'h00_0000;
  logic [15:0] len = 16'h0001;
  logic        req_rdy, rd_vld, busy, cont, wrap_en;
  logic [7:0]  rd_data, mem_d;
  logic [23:0] mem_a;
  logic        s_dis = 1'b1;
  logic [1:0]  s_len = 2'b00;
  logic [7:0]  rx_q[$];
  int          err_total = 0;
  int          check_count = 0;

  mrw_link_if link ();
  mrw_host_ctl #(.HALF_DIV(2)) i_mrw_host_ctl (.i_clk(clk), .i_reset(rst),
    .i_req_valid(vld), .o_req_ready(req_rdy), .i_req_cmd(cmd), .i_req_addr(adr),
    .i_req_stay_cont(stay), .i_req_wrap_dis(wdis), .i_req_wrap_len(wlen), .i_req_len(len),
    .o_rd_valid(rd_vld), .i_rd_ready(rdy), .o_rd_data(rd_data), .o_busy(busy),
    .o_cont_active(cont), .o_wrap_enabled(wrap_en), .link(link.host));
  mrw_flash_dev #(.MFR_ID(MFR), .DEV_ID(DEV)) i_mrw_flash_dev (.i_reset(rst),
    .i_quad_lines_enable_bit(qe), .i_mem_data(mem_d), .o_mem_addr(mem_a), .link(link.dev));
  mrw_link_sva #(.HALF_DIV(2)) i_mrw_link_sva (.i_clk(clk), .i_reset(rst),
    .sclk(link.sclk), .cs_n(link.cs_n), .host_io_o(link.host_io_o),
    .host_io_oe(link.host_io_oe), .dev_io_o(link.dev_io_o), .dev_io_oe(link.dev_io_oe));

  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  assign mem_d = mem(mem_a);

  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd_vld === 1'b1 && rdy) rx_q.push_back(rd_data);
  end

  function automatic logic [7:0] exp_b(input logic [7:0] c, input logic [23:0] a, input int i);
    logic [23:0] m;
    m = (24'h00_0008 << s_len) - 24'h00_0001;
    if (c == 8'h90) return (a[0] ^ i[0]) ? DEV : MFR;
    if (c == 8'hbb) return mem(a + 24'(i));
    if (!qe) return 8'hff;
    if (c == 8'he7) a[0] = 1'b0;
    if (s_dis) return mem(a + 24'(i));
    return mem((a & ~m) | ((a + 24'(i)) & m));
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // x[0]: stay or wrap disable, x[2:1]: wrap length
  task automatic run(input logic [7:0] c, input logic [23:0] a, input logic [2:0] x,
                     input int n);
    int t;
    @(posedge clk);
    vld <= 1'b1;
    cmd <= c;
    adr <= a;
    stay <= x[0];
    wdis <= x[0];
    wlen <= x[2:1];
    len <= 16'(n);
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (req_rdy !== 1'b1 && t < 9000);
    if (req_rdy !== 1'b1) begin
      err_total++;
      $display("FAIL %0t request refused", $time);
    end
    @(posedge clk);
    vld <= 1'b0;
    if (c == 8'h77) begin
      s_dis = x[0];
      s_len = x[2:1];
    end
    repeat (2) @(negedge clk);
    while ((rx_q.size() < n || busy !== 1'b0) && t < 20000) begin
      @(negedge clk);
      t++;
    end
    if (t >= 20000) begin
      err_total++;
      $display("FAIL %0t no completion", $time);
    end
    for (int i = 0; i < n; i++) chk8(rx_q[i], exp_b(c, a, i));
    rx_q.delete();
  endtask

  task automatic conclude();
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    err_total++;
    conclude();
  end

  initial begin
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    run(8'h90, 24'h00_0000, 3'h0, 4);
    run(8'h90, 24'h00_0001, 3'h0, 3);
    fork
      run(8'hbb, 24'h00_01fe, 3'h0, 8);
      begin
        @(posedge clk);
        rdy <= 1'b0;
        repeat (300) @(posedge clk);
        rdy <= 1'b1;
      end
    join
    run(8'heb, 24'h00_00fd, 3'h0, 5);
    for (int w = 0; w < 4; w++) begin
      run(8'h77, 24'h00_0000, {2'(w), 1'b0}, 0);
      chk8({7'h00, wrap_en}, 8'h01);
      run(w[0] ? 8'he7 : 8'heb, 24'h00_023b, 3'h0, (8 << w) + 3);
    end
    run(8'h77, 24'h00_0000, 3'h1, 0);
    chk8({7'h00, wrap_en}, 8'h00);
    run(8'heb, 24'h00_03fc, 3'h0, 6);
    run(8'hbb, 24'h00_0010, 3'h1, 3);
    chk8({7'h00, cont}, 8'h01);
    run(8'hbb, 24'h00_0020, 3'h1, 3);
    run(8'hbb, 24'h00_0030, 3'h0, 3);
    chk8({7'h00, cont}, 8'h00);
    run(8'heb, 24'h00_0040, 3'h1, 4);
    run(8'he7, 24'h00_0050, 3'h1, 4);
    run(8'hff, 24'h00_0000, 3'h0, 0);
    chk8({7'h00, cont}, 8'h00);
    run(8'hbb, 24'h00_0060, 3'h0, 2);
    @(posedge clk);
    qe <= 1'b0;
    run(8'heb, 24'h00_0070, 3'h0, 2);
    conclude();
  end
endmodule // tb_multi_io_read_wrap_id_frontend
